// File: sevr_cfg.svh
// Purpose: constants for the status event register block
// Assumes: one 20 MHz core clock
// Notes: bit positions and widths of both event groups
`ifndef SEVR_CFG_SVH
`define SEVR_CFG_SVH
`define SEVR_QUES_W 16
`define SEVR_STD_W 8
`define SEVR_QUES_USED 16'h0613
`define SEVR_STD_USED 8'hBD
`define SEVR_Q_VOLT 0
`define SEVR_Q_CURR 1
`define SEVR_Q_TEMP 4
`define SEVR_Q_OVP 9
`define SEVR_Q_OCP 10
`define SEVR_S_OP_COMPLETE 0
`define SEVR_S_QUERY_ERR 2
`define SEVR_S_DEV_ERR 3
`define SEVR_S_EXEC_ERR 4
`define SEVR_S_CMD_ERR 5
`define SEVR_S_POWER_CYCLE 7
`define SEVR_STB_QUES 3
`define SEVR_STB_STD_SUM 5
`define SEVR_STD_ERR_MASK 8'h3C
`define SEVR_QUES_MASK_RST 16'h0000
`define SEVR_STD_MASK_RST 8'h00
`endif

// File: sevr_ctrl_model.sv
// Purpose: remote controller model issuing status commands
// Assumes: one-cycle command strobe, read answer one cycle later
// Notes: write data is scrambled when not qualified
`timescale 1ns/1ps
`default_nettype none
module sevr_ctrl_model (
  input wire logic clk,
  input wire logic [15:0] rdata,
  input wire logic rdata_valid,
  output var logic cmd_valid,
  output var sevr_pkg::sevr_cmd_t cmd_code,
  output var logic [15:0] cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = sevr_pkg::SEVR_CMD_NONE;
    cmd_wdata = 16'h0000;
  end
  // mask values go out as binary-weighted sums
  task automatic send(input sevr_pkg::sevr_cmd_t c, input logic [15:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code <= sevr_pkg::SEVR_CMD_NONE;
    // stale data must not look valid
    cmd_wdata <= ~d;
  endtask : send
  task automatic query(input sevr_pkg::sevr_cmd_t c, output logic [15:0] d, output logic ok);
    send(c, 16'h0000);
    #1;
    ok = rdata_valid;
    d = rdata;
  endtask : query
endmodule : sevr_ctrl_model
`default_nettype wire

// File: sevr_latch.sv
// Purpose: one latched event register with enable mask and summary
// Assumes: set events are one-cycle or level inputs
// Notes: set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module sevr_latch #(
  parameter int W = 8,
  parameter logic [W-1:0] USED = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] set_in,
  input wire logic clr,
  input wire logic [W-1:0] mask,
  output logic [W-1:0] events,
  output logic summary
);
  logic [W-1:0] ev;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      if (USED[i]) begin : g_used
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n)
            ev[i] <= 1'b0;
          else if (set_in[i])
            ev[i] <= 1'b1;
          else if (clr)
            ev[i] <= 1'b0;
        end
      end else begin : g_zero
        assign ev[i] = 1'b0;
      end
    end
  endgenerate
  assign events = ev;
  assign summary = |(ev & mask);
endmodule : sevr_latch
`default_nettype wire

// File: sevr_mask.sv
// Purpose: writable, readable enable mask
// Assumes: reading never touches it
// Notes: power-on clear selectable
`timescale 1ns/1ps
`default_nettype none
module sevr_mask #(
  parameter int W = 8,
  parameter logic [W-1:0] USED = '1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_clr,
  input wire logic power_pulse,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] mask
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      mask <= RST;
    else if (wr)
      mask <= wdata & USED;
    else if (power_pulse && power_clr)
      mask <= '0;
  end
endmodule : sevr_mask
`default_nettype wire

// File: sevr_pkg.sv
// Purpose: types for the status event register block
// Assumes: nothing beyond the config header
// Notes: command codes decoded from the remote controller
package sevr_pkg;
  typedef enum logic [2:0] {
    SEVR_CMD_NONE,
    SEVR_CMD_CLS,
    SEVR_CMD_READ_QEV,
    SEVR_CMD_READ_SEV,
    SEVR_CMD_WRITE_QEN,
    SEVR_CMD_WRITE_SEN,
    SEVR_CMD_READ_QEN,
    SEVR_CMD_READ_SEN
  } sevr_cmd_t;
endpackage : sevr_pkg

// File: sevr_top.sv
// Purpose: questionable and standard event groups with status byte summaries
// Assumes: commands arrive as one-cycle strobes with decoded code
// Notes: masks persist through reset command, device clear and clear status
`include "sevr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sevr_top (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CMD_VALID,
  input wire sevr_pkg::sevr_cmd_t CMD_CODE,
  input wire logic [15:0] CMD_WDATA,
  input wire logic RESET_CMD,
  input wire logic DEVICE_CLEAR,
  input wire logic POWER_ON,
  input wire logic POWER_ON_CLEAR_SETTING,
  input wire logic VOLT_UNREG,
  input wire logic CURR_UNREG,
  input wire logic FAN_OVERTEMP,
  input wire logic OVP_TRIP,
  input wire logic OCP_TRIP,
  input wire logic OPERATION_COMPLETE_FLAG,
  input wire logic QUERY_ERROR,
  input wire logic DEVICE_ERROR,
  input wire logic EXECUTION_ERROR,
  input wire logic COMMAND_ERROR,
  output logic [15:0] RDATA,
  output logic RDATA_VALID,
  output logic STB_QUES,
  output logic STANDARD_GROUP_SUMMARY,
  output logic ERRQ_PUSH
);
  logic [`SEVR_QUES_W-1:0] q_set;
  logic [`SEVR_STD_W-1:0] s_set;
  logic [`SEVR_QUES_W-1:0] q_ev;
  logic [`SEVR_STD_W-1:0] s_ev;
  logic [`SEVR_QUES_W-1:0] q_mask;
  logic [`SEVR_STD_W-1:0] s_mask;
  logic q_sum;
  logic s_sum;
  logic power_seen;
  wire is_cls = CMD_VALID && (CMD_CODE == sevr_pkg::SEVR_CMD_CLS);
  wire rd_qev = CMD_VALID && (CMD_CODE == sevr_pkg::SEVR_CMD_READ_QEV);
  wire rd_sev = CMD_VALID && (CMD_CODE == sevr_pkg::SEVR_CMD_READ_SEV);
  wire rd_qen = CMD_VALID && (CMD_CODE == sevr_pkg::SEVR_CMD_READ_QEN);
  wire rd_sen = CMD_VALID && (CMD_CODE == sevr_pkg::SEVR_CMD_READ_SEN);
  wire wr_qen = CMD_VALID && (CMD_CODE == sevr_pkg::SEVR_CMD_WRITE_QEN);
  wire wr_sen = CMD_VALID && (CMD_CODE == sevr_pkg::SEVR_CMD_WRITE_SEN);
  wire clr_q = is_cls || rd_qev;
  wire clr_s = is_cls || rd_sev;
  // power-on pulse: first cycle after reset release, or an explicit power event
  wire power_pulse = POWER_ON || !power_seen;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N)
      power_seen <= 1'b0;
    else
      power_seen <= 1'b1;
  end
  always_comb begin
    q_set = '0;
    q_set[`SEVR_Q_VOLT] = VOLT_UNREG;
    q_set[`SEVR_Q_CURR] = CURR_UNREG;
    q_set[`SEVR_Q_TEMP] = FAN_OVERTEMP;
    q_set[`SEVR_Q_OVP] = OVP_TRIP;
    q_set[`SEVR_Q_OCP] = OCP_TRIP;
  end
  always_comb begin
    s_set = '0;
    s_set[`SEVR_S_OP_COMPLETE] = OPERATION_COMPLETE_FLAG;
    s_set[`SEVR_S_QUERY_ERR] = QUERY_ERROR;
    s_set[`SEVR_S_DEV_ERR] = DEVICE_ERROR;
    s_set[`SEVR_S_EXEC_ERR] = EXECUTION_ERROR;
    s_set[`SEVR_S_CMD_ERR] = COMMAND_ERROR;
    s_set[`SEVR_S_POWER_CYCLE] = power_pulse;
  end
  // widths fixed at 16 and 8
  sevr_latch #(.W(`SEVR_QUES_W), .USED(`SEVR_QUES_USED)) u_qev (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .set_in(q_set),
    .clr(clr_q),
    .mask(q_mask),
    .events(q_ev),
    .summary(q_sum)
  );
  sevr_latch #(.W(`SEVR_STD_W), .USED(`SEVR_STD_USED)) u_sev (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .set_in(s_set),
    .clr(clr_s),
    .mask(s_mask),
    .events(s_ev),
    .summary(s_sum)
  );
  sevr_mask #(.W(`SEVR_QUES_W), .USED(`SEVR_QUES_USED), .RST(`SEVR_QUES_MASK_RST)) u_qen (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .power_clr(1'b0),
    .power_pulse(1'b0),
    .wr(wr_qen),
    .wdata(CMD_WDATA),
    .mask(q_mask)
  );
  sevr_mask #(.W(`SEVR_STD_W), .USED(`SEVR_STD_USED), .RST(`SEVR_STD_MASK_RST)) u_sen (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .power_clr(POWER_ON_CLEAR_SETTING),
    .power_pulse(POWER_ON),
    .wr(wr_sen),
    .wdata(CMD_WDATA[`SEVR_STD_W-1:0]),
    .mask(s_mask)
  );
  // summaries stay combinational so a clear drops them at once
  assign STB_QUES = q_sum;
  assign STANDARD_GROUP_SUMMARY = s_sum;
  // read data is the plain binary value
  wire any_rd = rd_qev || rd_sev || rd_qen || rd_sen;
  wire [15:0] rd_mux = rd_qev ? q_ev :
                       rd_sev ? {8'h00, s_ev} :
                       rd_qen ? q_mask :
                       rd_sen ? {8'h00, s_mask} : 16'h0000;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 16'h0000;
      RDATA_VALID <= 1'b0;
    end else begin
      RDATA_VALID <= any_rd;
      if (any_rd)
        RDATA <= rd_mux;
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N)
      ERRQ_PUSH <= 1'b0;
    else
      ERRQ_PUSH <= |(s_set & `SEVR_STD_ERR_MASK);
  end

  property p_latch_hold;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (q_ev[`SEVR_Q_OVP] && !clr_q) |=> q_ev[`SEVR_Q_OVP];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("event bit dropped");
  property p_query_clears;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (rd_sev && !(|s_set)) |=> (s_ev == 8'h00);
  endproperty
  a_query_clears: assert property (p_query_clears) else $error("query did not clear");
  property p_reset_keeps;
    @(posedge CORE_CLK) disable iff (!RST_N)
      ((RESET_CMD || DEVICE_CLEAR) && !clr_q && !clr_s) |=>
        ((q_ev == $past(q_ev)) || $past(|q_set)) && ((s_ev == $past(s_ev)) || $past(|s_set));
  endproperty
  a_reset_keeps: assert property (p_reset_keeps) else $error("reset altered events");
  property p_read_value;
    @(posedge CORE_CLK) disable iff (!RST_N)
      rd_qev |=> RDATA_VALID && (RDATA == $past(q_ev));
  endproperty
  a_read_value: assert property (p_read_value) else $error("bad read data");
  sequence s_std_query;
    rd_sev;
  endsequence
  sequence s_std_answer;
    RDATA_VALID && (RDATA == {8'h00, $past(s_ev)});
  endsequence
  property p_std_read_value;
    @(posedge CORE_CLK) disable iff (!RST_N)
      s_std_query |=> s_std_answer;
  endproperty
  a_std_read_value: assert property (p_std_read_value) else $error("bad std read");
  property p_summary;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (clr_s && !(|s_set)) |=> !STANDARD_GROUP_SUMMARY;
  endproperty
  a_summary: assert property (p_summary) else $error("std summary kept after clear");
  property p_ques_clear_drop;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (clr_q && !(|q_set)) |=> !STB_QUES;
  endproperty
  a_ques_clear_drop: assert property (p_ques_clear_drop) else $error("ques summary kept");
  property p_cls_keeps_mask;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (is_cls && !POWER_ON) |=> (s_mask == $past(s_mask)) && (q_mask == $past(q_mask));
  endproperty
  a_cls_keeps_mask: assert property (p_cls_keeps_mask) else $error("mask lost on clear");
  property p_mask_read_keeps;
    @(posedge CORE_CLK) disable iff (!RST_N)
      ((rd_qen || rd_sen) && !POWER_ON) |=>
        RDATA_VALID && (q_mask == $past(q_mask)) && (s_mask == $past(s_mask));
  endproperty
  a_mask_read_keeps: assert property (p_mask_read_keeps) else $error("mask read changed");
  property p_ques_mask_write;
    @(posedge CORE_CLK) disable iff (!RST_N)
      wr_qen |=> (q_mask == ($past(CMD_WDATA) & `SEVR_QUES_USED));
  endproperty
  a_ques_mask_write: assert property (p_ques_mask_write) else $error("mask write lost");
  property p_ques_mask_hold;
    @(posedge CORE_CLK) disable iff (!RST_N)
      !wr_qen |=> (q_mask == $past(q_mask));
  endproperty
  a_ques_mask_hold: assert property (p_ques_mask_hold) else $error("ques mask changed");
  // push and record land on the same edge, both registered
  sequence s_std_error_in;
    |(s_set & `SEVR_STD_ERR_MASK);
  endsequence
  sequence s_push_recorded;
    ERRQ_PUSH && ((s_ev & `SEVR_STD_ERR_MASK) != 8'h00);
  endsequence
  property p_errq;
    @(posedge CORE_CLK) disable iff (!RST_N)
      s_std_error_in |=> s_push_recorded;
  endproperty
  a_errq: assert property (p_errq) else $error("no error queue push");
  property p_unused_zero;
    @(posedge CORE_CLK) disable iff (!RST_N)
      ((q_ev & ~`SEVR_QUES_USED) == 16'h0000) && ((s_ev & ~`SEVR_STD_USED) == 8'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");
  property p_volt_sets;
    @(posedge CORE_CLK) disable iff (!RST_N)
      VOLT_UNREG |=> q_ev[`SEVR_Q_VOLT];
  endproperty
  a_volt_sets: assert property (p_volt_sets) else $error("voltage bit not set");
  property p_curr_sets;
    @(posedge CORE_CLK) disable iff (!RST_N)
      CURR_UNREG |=> q_ev[`SEVR_Q_CURR];
  endproperty
  a_curr_sets: assert property (p_curr_sets) else $error("current bit not set");
  property p_fan_sets;
    @(posedge CORE_CLK) disable iff (!RST_N)
      FAN_OVERTEMP |=> q_ev[`SEVR_Q_TEMP];
  endproperty
  a_fan_sets: assert property (p_fan_sets) else $error("fan bit not set");
  property p_ovp_sets;
    @(posedge CORE_CLK) disable iff (!RST_N)
      OVP_TRIP |=> q_ev[`SEVR_Q_OVP];
  endproperty
  a_ovp_sets: assert property (p_ovp_sets) else $error("overvoltage bit not set");
  property p_ocp_sets;
    @(posedge CORE_CLK) disable iff (!RST_N)
      OCP_TRIP |=> q_ev[`SEVR_Q_OCP];
  endproperty
  a_ocp_sets: assert property (p_ocp_sets) else $error("overcurrent bit not set");
  property p_op_done_sets;
    @(posedge CORE_CLK) disable iff (!RST_N)
      OPERATION_COMPLETE_FLAG |=> s_ev[`SEVR_S_OP_COMPLETE];
  endproperty
  a_op_done_sets: assert property (p_op_done_sets) else $error("complete bit not set");
  property p_query_err_sets;
    @(posedge CORE_CLK) disable iff (!RST_N)
      QUERY_ERROR |=> s_ev[`SEVR_S_QUERY_ERR];
  endproperty
  a_query_err_sets: assert property (p_query_err_sets) else $error("query bit not set");
  property p_dev_err_sets;
    @(posedge CORE_CLK) disable iff (!RST_N)
      DEVICE_ERROR |=> s_ev[`SEVR_S_DEV_ERR];
  endproperty
  a_dev_err_sets: assert property (p_dev_err_sets) else $error("device bit not set");
  property p_exec_err_sets;
    @(posedge CORE_CLK) disable iff (!RST_N)
      EXECUTION_ERROR |=> s_ev[`SEVR_S_EXEC_ERR];
  endproperty
  a_exec_err_sets: assert property (p_exec_err_sets) else $error("exec bit not set");
  property p_cmd_err_sets;
    @(posedge CORE_CLK) disable iff (!RST_N)
      COMMAND_ERROR |=> s_ev[`SEVR_S_CMD_ERR];
  endproperty
  a_cmd_err_sets: assert property (p_cmd_err_sets) else $error("command bit not set");
  property p_power_sets;
    @(posedge CORE_CLK) disable iff (!RST_N)
      POWER_ON |=> s_ev[`SEVR_S_POWER_CYCLE];
  endproperty
  a_power_sets: assert property (p_power_sets) else $error("power bit not set");
  property p_power_clears_mask;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (POWER_ON && POWER_ON_CLEAR_SETTING && !wr_sen) |=> (s_mask == 8'h00);
  endproperty
  a_power_clears_mask: assert property (p_power_clears_mask) else $error("mask kept");
  property p_power_keeps_mask;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (POWER_ON && !POWER_ON_CLEAR_SETTING && !wr_sen) |=> (s_mask == $past(s_mask));
  endproperty
  a_power_keeps_mask: assert property (p_power_keeps_mask) else $error("mask lost");
endmodule : sevr_top
`default_nettype wire

// File: sevr_top_test.sv
// Purpose: self-checking bench for the status event registers
// Assumes: controller model drives the command port
// Notes: event inputs pulsed for one cycle
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module sevr_top_test;
  logic CORE_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [4:0] qe = 5'h00, se = 5'h00;
  logic [2:0] mx = 3'h0;
  logic clr_at_power = 1'b0;
  logic p;
  logic cv, rdv, stbq, stbe, errq;
  logic [15:0] wd, rdata;
  sevr_pkg::sevr_cmd_t cc;
  int fails = 0;
  int cmp_count = 0;
  localparam logic [15:0] QW [5] = '{16'h0001, 16'h0002, 16'h0010, 16'h0200, 16'h0400};
  localparam logic [15:0] SW [5] = '{16'h0001, 16'h0004, 16'h0008, 16'h0010, 16'h0020};
  always #25 CORE_CLK = ~CORE_CLK;
  sevr_ctrl_model m (.clk(CORE_CLK), .rdata(rdata), .rdata_valid(rdv),
    .cmd_valid(cv), .cmd_code(cc), .cmd_wdata(wd));
  sevr_top uut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CMD_VALID(cv), .CMD_CODE(cc),
    .CMD_WDATA(wd), .RESET_CMD(mx[0]), .DEVICE_CLEAR(mx[1]), .POWER_ON(mx[2]),
    .POWER_ON_CLEAR_SETTING(clr_at_power), .VOLT_UNREG(qe[0]), .CURR_UNREG(qe[1]),
    .FAN_OVERTEMP(qe[2]), .OVP_TRIP(qe[3]), .OCP_TRIP(qe[4]),
    .OPERATION_COMPLETE_FLAG(se[0]),
    .QUERY_ERROR(se[1]), .DEVICE_ERROR(se[2]), .EXECUTION_ERROR(se[3]),
    .COMMAND_ERROR(se[4]), .RDATA(rdata), .RDATA_VALID(rdv), .STB_QUES(stbq),
    .STANDARD_GROUP_SUMMARY(stbe), .ERRQ_PUSH(errq));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic rd(input sevr_pkg::sevr_cmd_t c, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    m.query(c, d, ok);
    `CHK("valid", 1'b1, ok)
    `CHK(c.name(), e, d)
  endtask : rd
  task automatic hit(input logic [4:0] q, input logic [4:0] s, input logic [2:0] x);
    @(posedge CORE_CLK);
    qe <= q;
    se <= s;
    mx <= x;
    @(posedge CORE_CLK);
    qe <= 5'h00;
    se <= 5'h00;
    mx <= 3'h0;
    #1 p = errq;
  endtask : hit
  initial begin
    #1000000;
    fails++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    rd(sevr_pkg::SEVR_CMD_READ_SEV, 16'h0080);
    rd(sevr_pkg::SEVR_CMD_READ_SEV, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      hit(5'h01 << i, 5'h00, 3'h0);
      rd(sevr_pkg::SEVR_CMD_READ_QEV, QW[i]);
      hit(5'h00, 5'h01 << i, 3'h0);
      `CHK("push", i > 0, p)
      rd(sevr_pkg::SEVR_CMD_READ_SEV, SW[i]);
    end
    hit(5'h1F, 5'h1F, 3'h0);
    rd(sevr_pkg::SEVR_CMD_READ_QEV, 16'h0613);
    rd(sevr_pkg::SEVR_CMD_READ_SEV, 16'h003D);
    m.send(sevr_pkg::SEVR_CMD_WRITE_QEN, 16'hFFFF);
    m.send(sevr_pkg::SEVR_CMD_WRITE_SEN, 16'h00FF);
    rd(sevr_pkg::SEVR_CMD_READ_QEN, 16'h0613);
    rd(sevr_pkg::SEVR_CMD_READ_QEN, 16'h0613);
    rd(sevr_pkg::SEVR_CMD_READ_SEN, 16'h00BD);
    hit(5'h04, 5'h10, 3'h3);
    `CHK("ques", 1'b1, stbq)
    `CHK("std_summary", 1'b1, stbe)
    hit(5'h00, 5'h00, 3'h3);
    `CHK("ques", 1'b1, stbq)
    rd(sevr_pkg::SEVR_CMD_READ_SEV, 16'h0020);
    `CHK("std_summary", 1'b0, stbe)
    m.send(sevr_pkg::SEVR_CMD_CLS, 16'h0000);
    #1 `CHK("ques", 1'b0, stbq)
    rd(sevr_pkg::SEVR_CMD_READ_QEV, 16'h0000);
    rd(sevr_pkg::SEVR_CMD_READ_QEN, 16'h0613);
    rd(sevr_pkg::SEVR_CMD_READ_SEN, 16'h00BD);
    m.send(sevr_pkg::SEVR_CMD_WRITE_QEN, 16'h0010);
    hit(5'h01, 5'h00, 3'h0);
    `CHK("ques", 1'b0, stbq)
    hit(5'h04, 5'h00, 3'h0);
    `CHK("ques", 1'b1, stbq)
    m.send(sevr_pkg::SEVR_CMD_WRITE_QEN, 16'h0000);
    rd(sevr_pkg::SEVR_CMD_READ_QEN, 16'h0000);
    // both power-on settings: clear first, then retain
    @(posedge CORE_CLK) clr_at_power <= 1'b1;
    hit(5'h00, 5'h00, 3'h4);
    rd(sevr_pkg::SEVR_CMD_READ_SEN, 16'h0000);
    rd(sevr_pkg::SEVR_CMD_READ_SEV, 16'h0080);
    m.send(sevr_pkg::SEVR_CMD_WRITE_SEN, 16'h0021);
    @(posedge CORE_CLK) clr_at_power <= 1'b0;
    hit(5'h00, 5'h00, 3'h4);
    rd(sevr_pkg::SEVR_CMD_READ_SEN, 16'h0021);
    m.send(sevr_pkg::SEVR_CMD_WRITE_SEN, 16'h0000);
    rd(sevr_pkg::SEVR_CMD_READ_SEN, 16'h0000);
    conclude();
  end
endmodule : sevr_top_test
`default_nettype wire
